// >>> tca_defs.svh
// Purpose: Constants for the transfer controller activation front end.
// Assumes: Byte addresses are 24 bits; RAM and vector words are 16 bits.
// Notes:   Offsets, counts and tables only; no logic here.
`ifndef TCA_DEFS_SVH
`define TCA_DEFS_SVH

`define TCA_NSRC 32
`define TCA_NEVT 16
`define TCA_EVT_SRC 5'h05
`define TCA_VEC_BASE 24'h000400
`define TCA_DESC_UPPER 8'hff
`define TCA_DESC_LAST 3'h5
`define TCA_DESC_BYTES 24'h00000c
`define TCA_RAM_LO 24'hffec00
`define TCA_RAM_HI 24'hffefff
`define TCA_FIFO_DEPTH 16
`define TCA_WORD_W 16
`define TCA_MEM_WORDS 1024
`define TCA_SW_ENA_BIT 7
// Descriptor word slots: mode A and source high, source low, mode B and
// destination high, destination low, count A, count B
`define TCA_W_SRC_HI 3'h0
`define TCA_W_SRC_LO 3'h1
`define TCA_W_DST_HI 3'h2
`define TCA_W_DST_LO 3'h3
// Hardware vector numbers, source 31 first, source 0 last
`define TCA_VEC_NUMS {7'd107, 7'd106, 7'd105, 7'd104, 7'd98, 7'd94, 7'd90, 7'd89, \
  7'd86, 7'd85, 7'd82, 7'd81, 7'd78, 7'd76, 7'd73, 7'd72, 7'd69, 7'd68, 7'd65, 7'd64, \
  7'd53, 7'd52, 7'd49, 7'd48, 7'd45, 7'd44, 7'd29, 7'd28, 7'd19, 7'd18, 7'd17, 7'd16}

`endif

// >>> tca_pkg.sv
// Purpose: Types and shared decoding for the activation front end.
// Assumes: tca_defs.svh is on the include path.
// Notes:   Source index order equals default priority order.
`include "tca_defs.svh"

package tca_pkg;

  typedef logic [6:0] tca_vec_t;
  typedef logic [15:0] tca_word_t;
  typedef logic [23:0] tca_addr_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_VEC, ST_DESC, ST_CNT_RD, ST_CNT_WR, ST_WAIT, ST_CLR
  } tca_state_e;

  localparam logic [`TCA_NSRC*7-1:0] TCA_VEC_TAB = `TCA_VEC_NUMS;

  // Vector number of a hardware source
  function automatic tca_vec_t tca_vec_num(input logic [4:0] idx);
    return TCA_VEC_TAB[idx*7 +: 7];
  endfunction

  // Lowest set bit wins; bit 5 of the result flags a hit
  function automatic logic [5:0] tca_pick(input logic [31:0] v);
    logic [5:0] r;
    r = 6'h00;
    for (int i = 31; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, 5'(i)};
      end
    end
    return r;
  endfunction

endpackage

// >>> tca_if.sv
// Purpose: Link between the transfer controller and the system around it.
// Assumes: Both ends share i_clk.
// Notes:   Clear strobes are one-cycle pulses; RAM uses req/ack.
`timescale 1ns/100ps

interface tca_if;
  logic [31:0] src_flag;
  logic [31:0] src_en;
  logic [31:0] flag_clr;
  logic [31:0] en_clr;
  logic sw_act;
  logic [6:0] sw_vec;
  logic sw_clr;
  logic ram_req;
  logic ram_we;
  logic [23:0] ram_addr;
  logic [15:0] ram_wdata;
  logic ram_ack;
  logic [15:0] ram_rdata;

  modport ctrl (
    input src_flag, src_en, sw_act, sw_vec, ram_ack, ram_rdata,
    output flag_clr, en_clr, sw_clr, ram_req, ram_we, ram_addr, ram_wdata
  );
  modport sys (
    output src_flag, src_en, sw_act, sw_vec, ram_ack, ram_rdata,
    input flag_clr, en_clr, sw_clr, ram_req, ram_we, ram_addr, ram_wdata
  );
endinterface

// >>> tca_ctrl.sv
// Purpose: Transfer controller activation, descriptor fetch, event counter.
// Assumes: Other party answers RAM requests and holds flags and enables.
// Notes:   Descriptor words, except those of the event source, leave through a 16-word FIFO.
`timescale 1ns/100ps
`include "tca_defs.svh"

// ----------------------------------------
// Descriptor FIFO
// ----------------------------------------
module tca_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ff;
  logic [AW-1:0] rd_ff;
  logic [AW:0] cnt_ff;
  logic [AW:0] nxt_cnt;
  logic push;
  logic pop;

  // Handshakes with honest full and empty
  assign o_ready = (cnt_ff != (AW+1)'(DEPTH));
  assign nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;
  assign o_data = mem_ff[rd_ff];

  // Storage
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_ff[wr_ff] <= i_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
      o_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_ff <= wr_ff + 1'b1;
      end
      if (pop) begin
        rd_ff <= rd_ff + 1'b1;
      end
      cnt_ff <= nxt_cnt;
      // Valid leaves straight from a flop
      o_valid <= (nxt_cnt != '0);
    end
  end
endmodule

module tca_ctrl
  import tca_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  tca_if.ctrl bus,
  input wire logic [15:0] i_event,
  output logic [15:0] o_event_status,
  output logic [15:0] o_desc_data,
  output logic o_desc_valid,
  input wire logic i_desc_ready,
  input wire logic i_xfer_done,
  input wire logic i_xfer_last,
  input wire logic i_xfer_clr_en,
  output logic o_busy
);
  tca_state_e state_ff;
  logic sw_sel_ff;
  logic [4:0] src_ff;
  logic [3:0] evt_ff;
  tca_addr_t desc_ff;
  logic [2:0] idx_ff;
  tca_addr_t sar_ff;
  tca_addr_t dar_ff;
  logic [15:0] ecs_ff;
  logic [15:0] ecs_clr_ff;
  logic ram_req_ff;
  logic ram_we_ff;
  tca_addr_t ram_addr_ff;
  tca_word_t ram_wdata_ff;
  logic [31:0] flag_clr_ff;
  logic [31:0] en_clr_ff;
  logic sw_clr_ff;
  logic [31:0] req;
  logic [5:0] win;
  logic [5:0] evt_win;
  logic is_evt;
  logic fifo_ready;
  logic push;
  logic need_ram;
  tca_vec_t vec;
  tca_addr_t nxt_ram_addr;

  // ----------------------------------------
  // Request gating and arbitration
  // ----------------------------------------
  // enable gates each source; no mask or level enters here
  // event request from any status bit
  always_comb begin
    req = bus.src_flag & bus.src_en;
    req[`TCA_EVT_SRC] = (|ecs_ff) && bus.src_en[`TCA_EVT_SRC];
  end
  assign win = tca_pick(req);
  // lowest pending event; arrival order plays no part
  assign evt_win = tca_pick({16'h0000, ecs_ff});
  assign is_evt = !sw_sel_ff && (src_ff == `TCA_EVT_SRC);
  // software vector; fixed vector per source
  assign vec = sw_sel_ff ? bus.sw_vec : tca_vec_num(src_ff);
  assign push = (state_ff == ST_DESC) && bus.ram_ack && !is_evt;
  assign need_ram = (state_ff == ST_VEC) || (state_ff == ST_CNT_RD) ||
                    (state_ff == ST_CNT_WR) ||
                    ((state_ff == ST_DESC) && (is_evt || fifo_ready));

  // Address of the next RAM access
  always_comb begin
    unique case (state_ff)
      ST_VEC: nxt_ram_addr = `TCA_VEC_BASE + {16'h0000, vec, 1'b0};
      ST_DESC: nxt_ram_addr = desc_ff + {20'h00000, idx_ff, 1'b0};
      ST_CNT_RD: nxt_ram_addr = {sar_ff[23:5], evt_ff, 1'b0};
      ST_CNT_WR: nxt_ram_addr = {dar_ff[23:5], evt_ff, 1'b0};
      default: nxt_ram_addr = ram_addr_ff;
    endcase
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  // source arbitration only in idle; the event pick is taken at the last descriptor word
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_ff <= ST_IDLE;
      sw_sel_ff <= 1'b0;
      src_ff <= 5'h00;
      evt_ff <= 4'h0;
      desc_ff <= 24'h000000;
      idx_ff <= 3'h0;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          // software or enabled request; software first
          if (bus.sw_act) begin
            sw_sel_ff <= 1'b1;
            state_ff <= ST_VEC;
          end else if (win[5]) begin
            sw_sel_ff <= 1'b0;
            src_ff <= win[4:0];
            state_ff <= ST_VEC;
          end
        end
        ST_VEC: if (bus.ram_ack) begin
          desc_ff <= {`TCA_DESC_UPPER, bus.ram_rdata};
          idx_ff <= 3'h0;
          state_ff <= ST_DESC;
        end
        ST_DESC: if (bus.ram_ack) begin
          idx_ff <= idx_ff + 3'h1;
          if (idx_ff == `TCA_DESC_LAST) begin
            evt_ff <= evt_win[3:0];
            state_ff <= is_evt ? ST_CNT_RD : ST_WAIT;
          end
        end
        ST_CNT_RD: if (bus.ram_ack) begin
          state_ff <= ST_CNT_WR;
        end
        ST_CNT_WR: if (bus.ram_ack) begin
          state_ff <= ST_CLR;
        end
        ST_WAIT: if (i_xfer_done) begin
          if (i_xfer_last) begin
            state_ff <= ST_CLR;
          end else begin
            desc_ff <= desc_ff + `TCA_DESC_BYTES;
            idx_ff <= 3'h0;
            state_ff <= ST_DESC;
          end
        end
        ST_CLR: state_ff <= ST_IDLE;
      endcase
    end
  end

  // Descriptor address fields kept for the count access
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sar_ff <= 24'h000000;
      dar_ff <= 24'h000000;
    end else if ((state_ff == ST_DESC) && bus.ram_ack) begin
      unique case (idx_ff)
        `TCA_W_SRC_HI: sar_ff[23:16] <= bus.ram_rdata[7:0];
        `TCA_W_SRC_LO: sar_ff[15:0] <= bus.ram_rdata;
        `TCA_W_DST_HI: dar_ff[23:16] <= bus.ram_rdata[7:0];
        `TCA_W_DST_LO: dar_ff[15:0] <= bus.ram_rdata;
        default: sar_ff <= sar_ff;
      endcase
    end
  end

  // ----------------------------------------
  // RAM requester
  // ----------------------------------------
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ram_req_ff <= 1'b0;
      ram_we_ff <= 1'b0;
      ram_addr_ff <= 24'h000000;
      ram_wdata_ff <= 16'h0000;
    end else if (bus.ram_ack) begin
      ram_req_ff <= 1'b0;
      if (state_ff == ST_CNT_RD) begin
        ram_wdata_ff <= bus.ram_rdata + 16'h0001;
      end
    end else if (!ram_req_ff && need_ram) begin
      ram_req_ff <= 1'b1;
      ram_we_ff <= (state_ff == ST_CNT_WR);
      ram_addr_ff <= nxt_ram_addr;
    end
  end

  // ----------------------------------------
  // Completion clears and event status
  // ----------------------------------------
  // clear the software request, event bit, enable or flag as the transfer ends
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      flag_clr_ff <= 32'h00000000;
      en_clr_ff <= 32'h00000000;
      sw_clr_ff <= 1'b0;
      ecs_clr_ff <= 16'h0000;
    end else begin
      flag_clr_ff <= 32'h00000000;
      en_clr_ff <= 32'h00000000;
      sw_clr_ff <= 1'b0;
      ecs_clr_ff <= 16'h0000;
      if (state_ff == ST_WAIT && i_xfer_done && i_xfer_last ||
          state_ff == ST_CNT_WR && bus.ram_ack) begin
        if (sw_sel_ff) begin
          sw_clr_ff <= 1'b1;
        end else if (is_evt) begin
          ecs_clr_ff[evt_ff] <= 1'b1;
        end else if (i_xfer_clr_en) begin
          en_clr_ff[src_ff] <= 1'b1;
        end else begin
          flag_clr_ff[src_ff] <= 1'b1;
        end
      end
    end
  end

  // pending bit absorbs repeats; a new event beats its clear
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ecs_ff <= 16'h0000;
    end else begin
      ecs_ff <= (ecs_ff & ~ecs_clr_ff) | i_event;
    end
  end

  // Outputs
  assign o_event_status = ecs_ff;
  assign bus.flag_clr = flag_clr_ff;
  assign bus.en_clr = en_clr_ff;
  assign bus.sw_clr = sw_clr_ff;
  assign bus.ram_req = ram_req_ff;
  assign bus.ram_we = ram_we_ff;
  assign bus.ram_addr = ram_addr_ff;
  assign bus.ram_wdata = ram_wdata_ff;

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_busy <= 1'b0;
    end else begin
      o_busy <= (state_ff != ST_IDLE);
    end
  end

  tca_fifo #(.WIDTH(`TCA_WORD_W), .DEPTH(`TCA_FIFO_DEPTH)) u_fifo (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_valid(push),
    .o_ready(fifo_ready),
    .i_data(bus.ram_rdata),
    .o_valid(o_desc_valid),
    .i_ready(i_desc_ready),
    .o_data(o_desc_data)
  );
endmodule

// >>> tca_sys.sv
// Purpose: System side: source flags, enables, software vector, RAM.
// Assumes: Software places descriptors in the RAM window, word aligned.
// Notes:   RAM answers one cycle after a request is seen.
`timescale 1ns/100ps
`include "tca_defs.svh"

module tca_sys
  import tca_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  tca_if.sys bus,
  input wire logic [31:0] i_irq,
  input wire logic i_en_wr,
  input wire logic [31:0] i_en_data,
  input wire logic i_sw_wr,
  input wire logic [7:0] i_sw_data,
  input wire logic i_ram_wr,
  input wire logic [23:0] i_ram_addr,
  input wire logic [15:0] i_ram_wdata,
  output logic [31:0] o_cpu_irq,
  output logic o_sw_done
);
  logic [31:0] flag_ff;
  logic [31:0] en_ff;
  logic [7:0] swv_ff;
  logic ack_ff;
  tca_word_t rdata_ff;
  tca_word_t mem_ff [`TCA_MEM_WORDS];

  // Vector area and RAM window share one array
  function automatic logic [9:0] mem_idx(input tca_addr_t a);
    return {a[23], a[9:1]};
  endfunction

  // ----------------------------------------
  // Flags, enables, software vector
  // ----------------------------------------
  // Sources set flags; a set beats a clear
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      flag_ff <= 32'h00000000;
    end else begin
      flag_ff <= (flag_ff & ~bus.flag_clr) | i_irq;
    end
  end

  // every enable maps to a source; a write beats a clear
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      en_ff <= 32'h00000000;
    end else if (i_en_wr) begin
      en_ff <= i_en_data;
    end else begin
      en_ff <= en_ff & ~bus.en_clr;
    end
  end

  // Software activation register; bit 7 requests
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      swv_ff <= 8'h00;
      o_sw_done <= 1'b0;
    end else begin
      o_sw_done <= bus.sw_clr;
      if (i_sw_wr) begin
        swv_ff <= i_sw_data;
      end else if (bus.sw_clr) begin
        swv_ff[`TCA_SW_ENA_BIT] <= 1'b0;
      end
    end
  end

  // Unrouted interrupts go to the CPU
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_cpu_irq <= 32'h00000000;
    end else begin
      o_cpu_irq <= flag_ff & ~en_ff;
    end
  end

  // ----------------------------------------
  // RAM and vector table
  // ----------------------------------------
  // software loads descriptors and vectors here
  always_ff @(posedge i_clk) begin
    if (bus.ram_req && bus.ram_we && !ack_ff) begin
      mem_ff[mem_idx(bus.ram_addr)] <= bus.ram_wdata;
    end else if (i_ram_wr) begin
      mem_ff[mem_idx(i_ram_addr)] <= i_ram_wdata;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ack_ff <= 1'b0;
      rdata_ff <= 16'h0000;
    end else begin
      ack_ff <= bus.ram_req && !ack_ff;
      rdata_ff <= mem_ff[mem_idx(bus.ram_addr)];
    end
  end

  assign bus.src_flag = flag_ff;
  assign bus.src_en = en_ff;
  assign bus.sw_act = swv_ff[`TCA_SW_ENA_BIT];
  assign bus.sw_vec = swv_ff[6:0];
  assign bus.ram_ack = ack_ff;
  assign bus.ram_rdata = rdata_ff;
endmodule

// >>> tca_monitor.sv
// Purpose: Watches the link between the controller and the system end.
// Assumes: One clock; reset is asynchronous and active high.
// Notes:   Sees only interface signals; helper flops track the last answers.
`timescale 1ns/100ps

module tca_monitor (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [31:0] src_flag,
  input wire logic [31:0] src_en,
  input wire logic [31:0] flag_clr,
  input wire logic [31:0] en_clr,
  input wire logic sw_act,
  input wire logic [6:0] sw_vec,
  input wire logic sw_clr,
  input wire logic ram_req,
  input wire logic ram_we,
  input wire logic [23:0] ram_addr,
  input wire logic [15:0] ram_wdata,
  input wire logic ram_ack,
  input wire logic [15:0] ram_rdata
);
  logic vec_hit;
  logic after_vec_ff;
  logic [15:0] vec_word_ff;
  logic [15:0] last_rd_ff;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  // Access falls in the vector table area
  assign vec_hit = (ram_addr[23:12] == 12'h000);

  // Vector word kept until the next answer arrives
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      after_vec_ff <= 1'b0;
      vec_word_ff <= 16'h0000;
    end else if (ram_ack) begin
      after_vec_ff <= vec_hit;
      vec_word_ff <= ram_rdata;
    end
  end

  // Last read word, the base of an increment
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      last_rd_ff <= 16'h0000;
    end else if (ram_ack && !ram_we) begin
      last_rd_ff <= ram_rdata;
    end
  end

  // ----------------------------------------
  // Link properties
  // ----------------------------------------
  property p_ack_one;
    ram_req && !ram_ack |=> ram_ack ##1 !ram_ack;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("answer not one cycle later");
  property p_req_hold;
    ram_req && !ram_ack |=> ram_req && $stable(ram_addr) && $stable(ram_we);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request moved before answer");
  property p_sw_vec;
    ram_req && vec_hit && sw_act |-> ram_addr == 24'h000400 + 24'({sw_vec, 1'b0});
  endproperty
  a_sw_vec: assert property (p_sw_vec) else $error("software vector address wrong");
  property p_vec_cause;
    ram_req && vec_hit |-> sw_act || (|(src_flag & src_en)) || src_en[5];
  endproperty
  a_vec_cause: assert property (p_vec_cause) else $error("start without enabled cause");
  property p_desc_addr;
    after_vec_ff && ram_req |-> ram_addr == {8'hff, vec_word_ff};
  endproperty
  a_desc_addr: assert property (p_desc_addr) else $error("descriptor not at vector word");
  property p_cnt_incr;
    ram_req && ram_we |-> ram_wdata == last_rd_ff + 16'h0001;
  endproperty
  a_cnt_incr: assert property (p_cnt_incr) else $error("count not incremented");
  property p_flag_clr;
    |flag_clr |-> $onehot(flag_clr) && (flag_clr & src_flag) == flag_clr && !sw_clr;
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("clear of an idle flag");
  property p_flag_gone;
    |flag_clr |=> (src_flag & $past(flag_clr)) == 32'h0;
  endproperty
  a_flag_gone: assert property (p_flag_gone) else $error("flag survived its clear");
  property p_en_clr;
    |en_clr |-> $onehot(en_clr) ##1 (src_en & $past(en_clr)) == 32'h0;
  endproperty
  a_en_clr: assert property (p_en_clr) else $error("enable survived its clear");
  property p_sw_clr;
    sw_clr |-> sw_act ##1 !sw_act;
  endproperty
  a_sw_clr: assert property (p_sw_clr) else $error("software request not dropped");
  property p_clr_quiet;
    (|flag_clr || |en_clr || sw_clr) |-> !ram_req;
  endproperty
  a_clr_quiet: assert property (p_clr_quiet) else $error("memory busy at clear");
endmodule

// >>> transfer_ctrl_activation_tb_top.sv
// Purpose: Drives both ends of the activation front end and judges results.
// Assumes: RAM is preloaded through the system end before any activation.
// Notes:   Inputs change at the falling clock edge.
`timescale 1ns/100ps

module transfer_ctrl_activation_tb_top;
  logic i_clk, i_sys_rst, i_desc_ready, i_xfer_done, i_xfer_last, i_xfer_clr_en;
  logic i_en_wr, i_sw_wr, i_ram_wr, o_desc_valid, o_busy, o_sw_done;
  logic [15:0] i_event, o_event_status, o_desc_data, i_ram_wdata;
  logic [31:0] i_irq, i_en_data, o_cpu_irq;
  logic [7:0] i_sw_data;
  logic [23:0] i_ram_addr;
  logic [23:0] wa[$];
  logic [15:0] wd[$];
  int fail_count, n_compared;

  // ----------------------------------------
  // Both ends and the checker
  // ----------------------------------------
  tca_if tca_if_inst();
  tca_ctrl tca_ctrl_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .bus(tca_if_inst),
    .i_event(i_event), .o_event_status(o_event_status), .o_desc_data(o_desc_data),
    .o_desc_valid(o_desc_valid), .i_desc_ready(i_desc_ready), .i_xfer_done(i_xfer_done),
    .i_xfer_last(i_xfer_last), .i_xfer_clr_en(i_xfer_clr_en), .o_busy(o_busy));
  tca_sys tca_sys_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .bus(tca_if_inst),
    .i_irq(i_irq), .i_en_wr(i_en_wr), .i_en_data(i_en_data), .i_sw_wr(i_sw_wr),
    .i_sw_data(i_sw_data), .i_ram_wr(i_ram_wr), .i_ram_addr(i_ram_addr),
    .i_ram_wdata(i_ram_wdata), .o_cpu_irq(o_cpu_irq), .o_sw_done(o_sw_done));
  tca_monitor tca_monitor_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .src_flag(tca_if_inst.src_flag), .src_en(tca_if_inst.src_en),
    .flag_clr(tca_if_inst.flag_clr), .en_clr(tca_if_inst.en_clr),
    .sw_act(tca_if_inst.sw_act), .sw_vec(tca_if_inst.sw_vec), .sw_clr(tca_if_inst.sw_clr),
    .ram_req(tca_if_inst.ram_req), .ram_we(tca_if_inst.ram_we),
    .ram_addr(tca_if_inst.ram_addr), .ram_wdata(tca_if_inst.ram_wdata),
    .ram_ack(tca_if_inst.ram_ack), .ram_rdata(tca_if_inst.ram_rdata));

  // Record count writes as the system end takes them
  always @(posedge i_clk) begin
    if (tca_if_inst.ram_req === 1'b1 && tca_if_inst.ram_ack === 1'b1 && tca_if_inst.ram_we) begin
      wa.push_back(tca_if_inst.ram_addr);
      wd.push_back(tca_if_inst.ram_wdata);
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(negedge i_clk);
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic timeout();
    fail_count++;
    $display("[ERR] %0t wait limit reached", $time);
    wrap_up();
  endtask

  task automatic ram_put(input logic [23:0] a, input logic [15:0] d);
    i_ram_addr = a;
    i_ram_wdata = d;
    tick(1);
  endtask

  // Six words tagged tag+0 .. tag+5 in layout order
  task automatic put_desc(input logic [23:0] a, input logic [15:0] tag);
    for (int k = 0; k < 6; k++) begin
      ram_put(a + 24'(2 * k), tag + 16'(k));
    end
  endtask

  task automatic set_en(input logic [31:0] v);
    i_en_wr = 1'b1;
    i_en_data = v;
    tick(1);
    i_en_wr = 1'b0;
  endtask

  // Drain one descriptor from the FIFO, checking word order
  task automatic pop_desc(input logic [15:0] tag);
    int n;
    for (int k = 0; k < 6; k++) begin
      n = 0;
      while (o_desc_valid !== 1'b1 && n < 300) begin
        tick(1);
        n++;
      end
      if (n == 300) begin
        timeout();
      end
      chk(o_desc_data, tag + 16'(k));
      i_desc_ready = 1'b1;
      tick(1);
      i_desc_ready = 1'b0;
      tick(1);
    end
  endtask

  task automatic finish_xfer(input logic last, input logic clr_en);
    i_xfer_done = 1'b1;
    i_xfer_last = last;
    i_xfer_clr_en = clr_en;
    tick(1);
    i_xfer_done = 1'b0;
    tick(1);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while ((o_busy !== 1'b0 || o_event_status !== 16'h0000) && n < 500) begin
      tick(1);
      n++;
    end
    if (n == 500) begin
      timeout();
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Software and two sources at once: software first, then lower index
  task automatic sc_prio();
    set_en(32'h00000009);
    i_irq = 32'h00000009;
    i_sw_wr = 1'b1;
    i_sw_data = 8'hbf;
    tick(1);
    i_irq = 32'h0;
    i_sw_wr = 1'b0;
    tick(1);
    chk(o_cpu_irq, 32'h0);
    pop_desc(16'h1100);
    finish_xfer(1'b1, 1'b0);
    chk(o_sw_done, 1'b1);
    pop_desc(16'h2200);
    finish_xfer(1'b1, 1'b0);
    chk(o_sw_done, 1'b0);
    pop_desc(16'h3300);
    finish_xfer(1'b1, 1'b0);
    wait_idle();
    chk(tca_if_inst.src_flag, 32'h0);
  endtask

  // Masked source goes to the CPU; chain ends by clearing the enable
  task automatic sc_chain();
    set_en(32'h00000004);
    i_irq = 32'h00000006;
    tick(1);
    i_irq = 32'h0;
    tick(2);
    chk(o_cpu_irq, 32'h00000002);
    pop_desc(16'h4400);
    finish_xfer(1'b0, 1'b0);
    chk(tca_if_inst.src_flag[2], 1'b1);
    pop_desc(16'h5500);
    finish_xfer(1'b1, 1'b1);
    wait_idle();
    chk(tca_if_inst.src_en, 32'h0);
    chk(o_cpu_irq, 32'h00000006);
  endtask

  // Events on pins 9, 3, 9 again: pin 3 counted first, repeat dropped
  task automatic sc_event();
    wa.delete();
    wd.delete();
    set_en(32'h00000020);
    i_event = 16'h0200;
    tick(1);
    i_event = 16'h0008;
    tick(1);
    i_event = 16'h0200;
    tick(1);
    i_event = 16'h0000;
    tick(1);
    chk(o_event_status, 16'h0208);
    wait_idle();
    chk(wa.size(), 2);
    chk(wa[0], 24'hffed06);
    chk(wd[0], 16'h0000);
    chk(wa[1], 24'hffed12);
    chk(wd[1], 16'h0011);
  endtask

  // Free-running clock
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  // Reset, preload, scenarios, verdict
  initial begin
    {i_sys_rst, i_desc_ready, i_xfer_done, i_xfer_last, i_xfer_clr_en} = 5'h10;
    {i_en_wr, i_sw_wr, i_ram_wr, i_event, i_irq, i_en_data} = 83'h0;
    {i_sw_data, i_ram_addr, i_ram_wdata} = 48'h0;
    fail_count = 0;
    n_compared = 0;
    tick(12);
    i_sys_rst = 1'b0;
    tick(2);
    i_ram_wr = 1'b1;
    ram_put(24'h00047e, 16'hec00);
    ram_put(24'h000420, 16'hec10);
    ram_put(24'h000426, 16'hec20);
    ram_put(24'h000424, 16'hec30);
    ram_put(24'h00043a, 16'hec60);
    put_desc(24'hffec00, 16'h1100);
    put_desc(24'hffec10, 16'h2200);
    put_desc(24'hffec20, 16'h3300);
    put_desc(24'hffec30, 16'h4400);
    put_desc(24'hffec3c, 16'h5500);
    ram_put(24'hffec60, 16'h00ff);
    ram_put(24'hffec62, 16'hed00);
    ram_put(24'hffec64, 16'h00ff);
    ram_put(24'hffec66, 16'hed00);
    ram_put(24'hffec68, 16'hffff);
    ram_put(24'hffec6a, 16'hffff);
    ram_put(24'hffed06, 16'hffff);
    ram_put(24'hffed12, 16'h0010);
    i_ram_wr = 1'b0;
    tick(2);
    sc_prio();
    sc_chain();
    sc_event();
    wrap_up();
  end
endmodule
